/* datalog_rtc_fault_log_regs.v */
`timescale 1ns/1ps
`include "datalog_rtc_consts.vh"

module datalog_rtc_fault_log_regs #(
    parameter SECOND_CYCLES = `CLOCK_HZ * `SECOND_S
) (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire [15:0] addr,
    input  wire [31:0] wdata,
    input  wire        wr_stb,
    input  wire        rd_stb,
    output reg  [31:0] rdata_q,
    input  wire [3:0]  fault_log_count_in,
    output reg  [3:0]  log_select_q,
    output reg         fetch_header_pulse_q,
    output reg         fetch_record_pulse_q,
    output reg  [15:0] record_index_q
);

    // ======================================================================
    // Declarations
    // ======================================================================
    reg  [31:0] date_set_q;
    reg  [31:0] time_set_q;
    reg  [15:0] fetch_header_q;
    reg         date_valid_q;
    reg         time_valid_q;
    reg  [23:0] time_snap_q;
    reg  [25:0] tick_cnt_q;
    reg         tick_q;
    reg  [31:0] rdata_d;
    wire        wr_time;
    wire        rd_date;
    wire [13:0] cal_year;
    wire [7:0]  cal_month;
    wire [7:0]  cal_day;
    wire [7:0]  cal_hour;
    wire [7:0]  cal_min;
    wire [7:0]  cal_sec;
    wire [31:0] date_word;
    wire [31:0] time_word;

    // Sized last count of the second period (period minus one) for the counter compare
    localparam [31:0] TICK_LAST_W = SECOND_CYCLES - 1;
    localparam [25:0] TICK_LAST   = TICK_LAST_W[25:0];

    // ======================================================================
    // Access decode strobes
    // ======================================================================
    assign wr_time = wr_stb && (addr == `ADDR_CLOCK_TIME_SET);
    assign rd_date = rd_stb && (addr == `ADDR_CLOCK_DATE_READ);

    // ======================================================================
    // Writable registers
    // ======================================================================
    // R1 R4 the set words are held whole; fields are sliced on commit
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            date_set_q     <= 32'h0000_0000;
            time_set_q     <= 32'h0000_0000;
            log_select_q   <= `LOG_SELECT_RESET;
            fetch_header_q <= 16'h0000;
            record_index_q <= 16'h0000;
        end else if (wr_stb) begin
            // R2 a date write alone only stores, it commits nothing
            if (addr == `ADDR_CLOCK_DATE_SET) begin
                date_set_q <= wdata;
            end else if (addr == `ADDR_CLOCK_TIME_SET) begin
                time_set_q <= wdata;
            end else if (addr == `ADDR_FAULT_LOG_SELECT) begin
                // R11 indices past the last log are ignored
                if (wdata[15:0] <= {12'h000, `LOG_SELECT_MAX}) begin
                    log_select_q <= wdata[3:0];
                end
            end else if (addr == `ADDR_FETCH_HEADER) begin
                fetch_header_q <= wdata[15:0];
            end else if (addr == `ADDR_FETCH_RECORD) begin
                record_index_q <= wdata[15:0];
            end
        end
    end

    // ======================================================================
    // Fetch request pulses to the log reader
    // ======================================================================
    // R12 only a value of one starts a header fetch
    // R13 every record write starts a record fetch
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            fetch_header_pulse_q <= 1'b0;
            fetch_record_pulse_q <= 1'b0;
        end else begin
            fetch_header_pulse_q <= wr_stb &&
                                    (addr == `ADDR_FETCH_HEADER) &&
                                    (wdata[15:0] == `FETCH_HEADER_GO);
            fetch_record_pulse_q <= wr_stb && (addr == `ADDR_FETCH_RECORD);
        end
    end

    // ======================================================================
    // Set-since-reset flags
    // ======================================================================
    // R5 R6 both flags rise on the commit, cleared only by reset
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            date_valid_q <= 1'b0;
            time_valid_q <= 1'b0;
        end else if (wr_time) begin
            date_valid_q <= 1'b1;
            time_valid_q <= 1'b1;
        end
    end

    // ======================================================================
    // One-second tick
    // ======================================================================
    // Restarted on commit so that the first second after a set is not shortened
    // by up to one period; between commits it runs freely.
    always @(posedge ref_clk) begin
        if (!rst_n || wr_time) begin
            tick_cnt_q <= 26'h000_0000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == TICK_LAST) begin
            tick_cnt_q <= 26'h000_0000;
            tick_q     <= time_valid_q;
        end else begin
            tick_cnt_q <= tick_cnt_q + 26'h000_0001;
            tick_q     <= 1'b0;
        end
    end

    // ======================================================================
    // Calendar
    // ======================================================================
    // R2 date and time land together on the time write
    // R16 counting only starts once the clock was committed
    rtc_calendar u_calendar (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .load     (wr_time),
        .tick     (tick_q),
        .year_in  (date_set_q[`YEAR_HI:`YEAR_LO]),
        .month_in (date_set_q[`MONTH_HI:`MONTH_LO]),
        .day_in   (date_set_q[`DAY_HI:`DAY_LO]),
        .hour_in  (wdata[`HOUR_HI:`HOUR_LO]),
        .min_in   (wdata[`MIN_HI:`MIN_LO]),
        .sec_in   (wdata[`SEC_HI:`SEC_LO]),
        .year_q   (cal_year),
        .month_q  (cal_month),
        .day_q    (cal_day),
        .hour_q   (cal_hour),
        .min_q    (cal_min),
        .sec_q    (cal_sec)
    );

    // ======================================================================
    // Read words
    // ======================================================================
    // R5 live date with flag in bit 14, bit 15 zero
    assign date_word = {cal_day, cal_month, 1'b0, date_valid_q, cal_year};
    // R6 captured time with flag in bit 31, bits 30..24 zero
    assign time_word = {time_valid_q, 7'h00, time_snap_q};

    // R7 date read freezes the time for the following time read
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            time_snap_q <= 24'h00_0000;
        end else if (rd_date) begin
            time_snap_q <= {cal_sec, cal_min, cal_hour};
        end
    end

    // ======================================================================
    // Read data mux
    // ======================================================================
    // Unmapped and factory addresses read as zero
    always @* begin
        rdata_d = 32'h0000_0000;
        if (addr == `ADDR_MODEL_IDENTIFIER) begin
            // R14 identifier value is arbitrary
            rdata_d = {16'h0000, `MODEL_IDENTIFIER_VAL};
        end else if (addr == `ADDR_MODEL_LENGTH) begin
            // R14 fixed length
            rdata_d = {16'h0000, `MODEL_LENGTH_VAL};
        end else if (addr == `ADDR_CLOCK_DATE_SET) begin
            rdata_d = date_set_q;
        end else if (addr == `ADDR_CLOCK_TIME_SET) begin
            rdata_d = time_set_q;
        end else if (addr == `ADDR_CLOCK_DATE_READ) begin
            rdata_d = date_word;
        end else if (addr == `ADDR_CLOCK_TIME_READ) begin
            // R8 coherent only after a date read
            rdata_d = time_word;
        end else if (addr == `ADDR_SAMPLE_PERIOD) begin
            // R9 fixed period
            rdata_d = {16'h0000, `SAMPLE_PERIOD_MS};
        end else if (addr == `ADDR_FAULT_LOG_COUNT) begin
            // R10 count from the log store
            rdata_d = {28'h000_0000, fault_log_count_in};
        end else if (addr == `ADDR_FAULT_LOG_SELECT) begin
            rdata_d = {28'h000_0000, log_select_q};
        end else if (addr == `ADDR_FETCH_HEADER) begin
            rdata_d = {16'h0000, fetch_header_q};
        end else if (addr == `ADDR_FETCH_RECORD) begin
            rdata_d = {16'h0000, record_index_q};
        end else if (addr == `ADDR_FACTORY_COMMAND_A ||
                     addr == `ADDR_FACTORY_STATUS ||
                     addr == `ADDR_FACTORY_COMMAND_B) begin
            // R15 reserved, read-only zero, writes dropped
            rdata_d = 32'h0000_0000;
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_stb) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

endmodule

/* datalog_rtc_consts.vh */
// How it works
// R1 - Date-set word: year bits 13..0, month 23..16, day 31..24; 15..14 ignored.
// R2 - Written date waits and is committed only when the time word is written.
// R3 - Host writes the date word first, then the time word.
// R4 - Time-set word: hours 7..0, minutes 15..8, seconds 23..16, top byte unused.
// R5 - Date read gives year, month, day and a date-set-since-reset flag in bit 14.
// R6 - Time read gives the same fields plus a time-set flag in bit 31.
// R7 - Reading the date captures the time; later time reads return that capture.
// R8 - Host reads the date word before the time word for a coherent pair.
// R9 - Sample period register is read-only and reports one millisecond.
// R10 - Log count register is read-only and reports valid logs, 0 to 12.
// R11 - Log select takes 0 to 11, default 0, naming the log to fetch from.
// R12 - Writing 1 to fetch-header requests the selected header; 0 does nothing.
// R13 - Writing a record number requests that record of the selected log.
// R14 - Header holds a read-only model identifier and a length of 126.
// R15 - Factory command and status registers are read-only with no function.
// R16 - Once committed, the clock advances each second with calendar rollover.
`ifndef DATALOG_RTC_CONSTS_VH
`define DATALOG_RTC_CONSTS_VH

// ==========================================================================
// Register addresses
// ==========================================================================
`define ADDR_MODEL_IDENTIFIER   16'h9ddb
`define ADDR_MODEL_LENGTH       16'h9ddc
`define ADDR_CLOCK_DATE_SET     16'h9ddd
`define ADDR_CLOCK_TIME_SET     16'h9ddf
`define ADDR_CLOCK_DATE_READ    16'h9de1
`define ADDR_CLOCK_TIME_READ    16'h9de3
`define ADDR_SAMPLE_PERIOD      16'h9de5
`define ADDR_FAULT_LOG_COUNT    16'h9de6
`define ADDR_FACTORY_COMMAND_A  16'h9de7
`define ADDR_FACTORY_STATUS     16'h9de8
`define ADDR_FAULT_LOG_SELECT   16'h9de9
`define ADDR_FETCH_HEADER       16'h9dea
`define ADDR_FETCH_RECORD       16'h9deb
`define ADDR_FACTORY_COMMAND_B  16'h9dec

// ==========================================================================
// Fixed values
// ==========================================================================
`define MODEL_IDENTIFIER_VAL    16'h5a5a
`define MODEL_LENGTH_VAL        16'h007e
`define SAMPLE_PERIOD_MS        16'h0001
`define LOG_SELECT_MAX          4'hb
`define LOG_SELECT_RESET        4'h0
`define FETCH_HEADER_GO         16'h0001

// ==========================================================================
// Field positions
// ==========================================================================
`define YEAR_HI                 13
`define YEAR_LO                 0
`define DATE_FLAG_BIT           14
`define MONTH_HI                23
`define MONTH_LO                16
`define DAY_HI                  31
`define DAY_LO                  24
`define HOUR_HI                 7
`define HOUR_LO                 0
`define MIN_HI                  15
`define MIN_LO                  8
`define SEC_HI                  23
`define SEC_LO                  16
`define TIME_FLAG_BIT           31

// ==========================================================================
// Calendar limits and timing
// ==========================================================================
`define SEC_LAST                8'h3b
`define MIN_LAST                8'h3b
`define HOUR_LAST               8'h17
`define MONTH_LAST              8'h0c
`define MONTH_FEB               8'h02
`define FIRST_OF                8'h01
`define CLOCK_HZ                40000000
`define SECOND_S                1

`endif

/* rtc_calendar.v */
`timescale 1ns/1ps
`include "datalog_rtc_consts.vh"

module rtc_calendar (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        load,
    input  wire        tick,
    input  wire [13:0] year_in,
    input  wire [7:0]  month_in,
    input  wire [7:0]  day_in,
    input  wire [7:0]  hour_in,
    input  wire [7:0]  min_in,
    input  wire [7:0]  sec_in,
    output reg  [13:0] year_q,
    output reg  [7:0]  month_q,
    output reg  [7:0]  day_q,
    output reg  [7:0]  hour_q,
    output reg  [7:0]  min_q,
    output reg  [7:0]  sec_q
);

    // ======================================================================
    // Days in current month
    // ======================================================================
    reg        leap;
    reg [7:0]  month_days;

    // Gregorian leap rule, constant moduli only
    always @* begin
        leap = (year_q % 14'd4 == 14'd0) &&
               ((year_q % 14'd100 != 14'd0) ||
                (year_q % 14'd400 == 14'd0));
        case (month_q)
            8'h04, 8'h06, 8'h09, 8'h0b: month_days = 8'h1e;
            `MONTH_FEB:                 month_days = leap ? 8'h1d : 8'h1c;
            default:                    month_days = 8'h1f;
        endcase
    end

    // ======================================================================
    // Counting
    // ======================================================================
    // R16 second rollover chain; load beats a tick in the same cycle
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            year_q  <= 14'h0000;
            month_q <= 8'h00;
            day_q   <= 8'h00;
            hour_q  <= 8'h00;
            min_q   <= 8'h00;
            sec_q   <= 8'h00;
        end else if (load) begin
            year_q  <= year_in;
            month_q <= month_in;
            day_q   <= day_in;
            hour_q  <= hour_in;
            min_q   <= min_in;
            sec_q   <= sec_in;
        end else if (tick) begin
            if (sec_q < `SEC_LAST) begin
                sec_q <= sec_q + 8'h01;
            end else begin
                sec_q <= 8'h00;
                if (min_q < `MIN_LAST) begin
                    min_q <= min_q + 8'h01;
                end else begin
                    min_q <= 8'h00;
                    if (hour_q < `HOUR_LAST) begin
                        hour_q <= hour_q + 8'h01;
                    end else begin
                        hour_q <= 8'h00;
                        // Out-of-range written days still roll cleanly
                        if (day_q < month_days) begin
                            day_q <= day_q + 8'h01;
                        end else begin
                            day_q <= `FIRST_OF;
                            if (month_q < `MONTH_LAST) begin
                                month_q <= month_q + 8'h01;
                            end else begin
                                month_q <= `FIRST_OF;
                                year_q  <= year_q + 14'h0001;
                            end
                        end
                    end
                end
            end
        end
    end

endmodule

/* datalog_rtc_fault_log_regs_props.sv */
`timescale 1ns/1ps
`include "datalog_rtc_consts.vh"

module datalog_rtc_fault_log_regs_props #(
    parameter SECOND_CYCLES = 10
) (
    input wire        ref_clk,
    input wire        rst_n,
    input wire [15:0] addr,
    input wire [31:0] wdata,
    input wire        wr_stb,
    input wire        rd_stb,
    input wire [31:0] rdata_q,
    input wire [3:0]  fault_log_count_in,
    input wire [3:0]  log_select_q,
    input wire        fetch_header_pulse_q,
    input wire        fetch_record_pulse_q,
    input wire [15:0] record_index_q
);
    // ======================================================================
    // Clocking and access steps
    // ======================================================================
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence commit_s;
        wr_stb && addr == `ADDR_CLOCK_TIME_SET;
    endsequence
    sequence date_rd_s;
        rd_stb && addr == `ADDR_CLOCK_DATE_READ;
    endsequence
    sequence time_rd_s;
        rd_stb && addr == `ADDR_CLOCK_TIME_READ;
    endsequence

    // ======================================================================
    // Read-only registers
    // ======================================================================
    len_read_a: assert property (
        rd_stb && addr == `ADDR_MODEL_LENGTH |=> rdata_q == 32'h0000007e)
        else $error("model length read wrong");
    period_read_a: assert property (
        rd_stb && addr == `ADDR_SAMPLE_PERIOD |=> rdata_q == 32'h00000001)
        else $error("sample period read wrong");
    count_read_a: assert property (
        rd_stb && addr == `ADDR_FAULT_LOG_COUNT
        |=> rdata_q == {28'h0000000, $past(fault_log_count_in)})
        else $error("log count read wrong");
    factory_read_a: assert property (
        rd_stb && (addr == `ADDR_FACTORY_COMMAND_A ||
        addr == `ADDR_FACTORY_STATUS || addr == `ADDR_FACTORY_COMMAND_B)
        |=> rdata_q == 32'h00000000)
        else $error("factory read not zero");

    // ======================================================================
    // Fault log navigation
    // ======================================================================
    hdr_go_a: assert property (
        wr_stb && addr == `ADDR_FETCH_HEADER && wdata[15:0] == 16'h0001
        |=> fetch_header_pulse_q)
        else $error("header fetch pulse missing");
    hdr_cause_a: assert property (
        fetch_header_pulse_q |-> $past(wr_stb)
        && $past(wdata[15:0]) == 16'h0001
        && $past(addr) == `ADDR_FETCH_HEADER)
        else $error("header fetch pulse without request");
    rec_fetch_a: assert property (
        wr_stb && addr == `ADDR_FETCH_RECORD
        |=> fetch_record_pulse_q && record_index_q == $past(wdata[15:0]))
        else $error("record fetch wrong");
    sel_write_a: assert property (
        wr_stb && addr == `ADDR_FAULT_LOG_SELECT && wdata[15:0] <= 16'h000b
        |=> log_select_q == $past(wdata[3:0]))
        else $error("log select not taken");
    sel_hold_a: assert property (
        !(wr_stb && addr == `ADDR_FAULT_LOG_SELECT && wdata[15:0] <= 16'h000b)
        |=> $stable(log_select_q))
        else $error("log select changed");

    // ======================================================================
    // Clock set flags
    // ======================================================================
    date_flag_a: assert property (
        commit_s ##[1:4] date_rd_s |=> rdata_q[`DATE_FLAG_BIT])
        else $error("date flag not set");
    time_flag_a: assert property (
        commit_s ##[1:4] date_rd_s ##[1:4] time_rd_s
        |=> rdata_q[`TIME_FLAG_BIT])
        else $error("time flag not set");
endmodule

bind datalog_rtc_fault_log_regs datalog_rtc_fault_log_regs_props #(
    .SECOND_CYCLES(SECOND_CYCLES)
) datalog_rtc_fault_log_regs_props_i (
    .ref_clk              (ref_clk),
    .rst_n                (rst_n),
    .addr                 (addr),
    .wdata                (wdata),
    .wr_stb               (wr_stb),
    .rd_stb               (rd_stb),
    .rdata_q              (rdata_q),
    .fault_log_count_in   (fault_log_count_in),
    .log_select_q         (log_select_q),
    .fetch_header_pulse_q (fetch_header_pulse_q),
    .fetch_record_pulse_q (fetch_record_pulse_q),
    .record_index_q       (record_index_q)
);

/* tb_datalog_rtc_fault_log_regs.sv */
`timescale 1ns/1ps
`include "datalog_rtc_consts.vh"

module tb_datalog_rtc_fault_log_regs;
    // Short second keeps calendar tests within a few hundred cycles
    localparam int SEC_CYC = 10;
    logic        ref_clk;
    logic        rst_n;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rdata_q;
    logic [3:0]  fault_log_count_in;
    logic [3:0]  log_select_q;
    logic        fetch_header_pulse_q;
    logic        fetch_record_pulse_q;
    logic [15:0] record_index_q;
    logic [31:0] snap;
    logic [31:0] rec_word;
    int          fail_count;
    int          num_checks;
    // Plain reads: address, log count driven, expected word
    logic [15:0] row_addr [0:11] = '{`ADDR_MODEL_IDENTIFIER,
        `ADDR_MODEL_LENGTH, `ADDR_SAMPLE_PERIOD, `ADDR_FAULT_LOG_COUNT,
        `ADDR_FAULT_LOG_COUNT, `ADDR_FACTORY_COMMAND_A, `ADDR_FACTORY_STATUS,
        `ADDR_FACTORY_COMMAND_B, `ADDR_FAULT_LOG_SELECT,
        `ADDR_CLOCK_DATE_READ, `ADDR_CLOCK_TIME_READ, 16'h9ded};
    logic [3:0]  row_cnt [0:11] = '{4'hc, 4'hc, 4'hc, 4'hc, 4'h0, 4'h0,
        4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
    logic [31:0] row_exp [0:11] = '{32'h00005a5a, 32'h0000007e,
        32'h00000001, 32'h0000000c, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0};
    // Last second of a day: date set, date expected after one tick
    logic [31:0] roll_set [0:2] = '{32'h1f0c07e7, 32'h1c0207e8, 32'h1c0207e7};
    logic [31:0] roll_exp [0:2] = '{32'h010147e8, 32'h1d0247e8, 32'h010347e7};

    datalog_rtc_fault_log_regs #(
        .SECOND_CYCLES(SEC_CYC)
    ) datalog_rtc_fault_log_regs_i (
        .ref_clk              (ref_clk),
        .rst_n                (rst_n),
        .addr                 (addr),
        .wdata                (wdata),
        .wr_stb               (wr_stb),
        .rd_stb               (rd_stb),
        .rdata_q              (rdata_q),
        .fault_log_count_in   (fault_log_count_in),
        .log_select_q         (log_select_q),
        .fetch_header_pulse_q (fetch_header_pulse_q),
        .fetch_record_pulse_q (fetch_record_pulse_q),
        .record_index_q       (record_index_q)
    );

    // Record fetch outputs seen as one word
    assign rec_word = {15'h0, fetch_record_pulse_q, record_index_q};

    // ======================================================================
    // Bus tasks and checks
    // ======================================================================
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
        #1;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata_q;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp,
                          input string what);
        logic [31:0] d;
        bus_rd(a, d);
        check(what, exp, d);
    endtask

    task automatic do_reset;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask

    task automatic summarize;
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ======================================================================
    // Clock, watchdog and test sequence
    // ======================================================================
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        fail_count++;
        summarize();
    end

    initial begin
        rst_n = 1'b0; addr = 16'h0; wdata = 32'h0; wr_stb = 1'b0;
        rd_stb = 1'b0; fault_log_count_in = 4'hc;
        fail_count = 0; num_checks = 0;
        do_reset();
        // Second pass runs after writes to every read-only place
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 12 && p == 1; i++) bus_wr(row_addr[i], '1);
            for (int i = 0; i < 12; i++) begin
                @(posedge ref_clk);
                fault_log_count_in <= row_cnt[i];
                rd_chk(row_addr[i], row_exp[i], "plain read");
            end
        end
        bus_wr(`ADDR_CLOCK_DATE_SET, 32'h150307e1);
        rd_chk(`ADDR_CLOCK_DATE_READ, 32'h0, "date before commit");
        bus_wr(`ADDR_CLOCK_TIME_SET, 32'h0000300d);
        rd_chk(`ADDR_CLOCK_DATE_READ, 32'h150347e1, "date");
        rd_chk(`ADDR_CLOCK_TIME_READ, 32'h8000300d, "time");
        repeat (100) @(posedge ref_clk);
        rd_chk(`ADDR_CLOCK_DATE_READ, 32'h150347e1, "date later");
        bus_rd(`ADDR_CLOCK_TIME_READ, snap);
        check("time hh mm", 32'h8000300d, snap & 32'hff00ffff);
        // Ten ticks of ten cycles each fall between commit and capture
        check("seconds run", 32'h0000000a, {24'h0, snap[23:16]});
        repeat (30) @(posedge ref_clk);
        rd_chk(`ADDR_CLOCK_TIME_READ, snap, "time snapshot");
        for (int i = 0; i < 3; i++) begin
            bus_wr(`ADDR_CLOCK_DATE_SET, roll_set[i]);
            bus_wr(`ADDR_CLOCK_TIME_SET, 32'h003b3b17);
            repeat (12) @(posedge ref_clk);
            rd_chk(`ADDR_CLOCK_DATE_READ, roll_exp[i], "rollover date");
            rd_chk(`ADDR_CLOCK_TIME_READ, 32'h80000000, "rollover time");
        end
        bus_wr(`ADDR_FAULT_LOG_SELECT, 32'h0000000b);
        bus_wr(`ADDR_FAULT_LOG_SELECT, 32'h0000000c);
        check("log select", 32'hb, {28'h0, log_select_q});
        rd_chk(`ADDR_FAULT_LOG_SELECT, 32'h0000000b, "select read");
        bus_wr(`ADDR_FETCH_HEADER, 32'h0);
        check("header nop", 32'h0, {31'h0, fetch_header_pulse_q});
        bus_wr(`ADDR_FETCH_HEADER, 32'h1);
        check("header go", 32'h1, {31'h0, fetch_header_pulse_q});
        @(posedge ref_clk);
        #1;
        check("header end", 32'h0, {31'h0, fetch_header_pulse_q});
        // Back-to-back record fetches at both ends of the range
        @(posedge ref_clk);
        addr   <= `ADDR_FETCH_RECORD;
        wdata  <= 32'h0;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wdata  <= 32'hffff;
        #1;
        check("record 0", 32'h10000, rec_word);
        @(posedge ref_clk);
        wr_stb <= 1'b0;
        #1;
        check("record max", 32'h1ffff, rec_word);
        @(posedge ref_clk);
        #1;
        check("record end", 32'h0, {31'h0, fetch_record_pulse_q});
        do_reset();
        check("select reset", 32'h0, {28'h0, log_select_q});
        rd_chk(`ADDR_CLOCK_DATE_READ, 32'h0, "date after reset");
        rd_chk(`ADDR_CLOCK_TIME_READ, 32'h0, "time after reset");
        summarize();
    end
endmodule
